// ---- hw/panel_ctrl.sv ----
// front-panel controller: power-on check, operator test, display exercise, unit code entry
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// R1 - good power: all lamps flash, then power good, write protect, unit code
// R2 - supply failure: power fail and fault lamps on, power good off, code shown
// R3 - reset then select enters diagnostics, diag lamp on, shows 01
// R4 - run on test 01 steps display 000 to 999 with equal digits
// R5 - during display exercise all lamps on except power fail, tape start, fault
// R6 - test done: rewind-unload, show 00 with fault lamp, stay in diagnostics
// R7 - fault during test stops it, shows fault code, fault lamp on
// R8 - reset press in diagnostics returns to normal operation
// R9 - reset press while fault shown clears fault so test can rerun
// R10 - unit code 0 to 255 held, entered as three decimal digits
// R11 - unit code kept in nonvolatile store until a new code is entered
// R12 - display shows unit code except during fault or panel diagnostic
// R13 - in diagnostics advance increments the procedure number by one
// R14 - run with procedure 04 opens unit code entry showing 000
// R15 - entry: advance bumps lowest digit, select shifts left with zero fill
// R16 - run in entry stores code, shows 00; reset returns with new code
// R17 - entered value above 255 refused, old code kept, fault shown
module panel_ctrl
  import panel_pkg::*;
#(
  parameter int LAMP_TEST_CYCLES  = panel_pkg::LAMP_TEST_CYC,
  parameter int DIGIT_STEP_CYCLES = panel_pkg::DIGIT_STEP_CYC
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_nrst,
  input  wire panel_pkg::keys_t  i_keys,
  input  wire logic              i_power_ok,
  input  wire panel_pkg::status_t i_status,
  input  wire logic              i_test_done,
  input  wire logic              i_test_fault,
  input  wire logic [11:0]       i_test_fault_code,
  input  wire logic [7:0]        i_nvm_code,
  output panel_pkg::lamps_t      o_lamps,
  output panel_pkg::disp_t       o_display,
  output logic [7:0]             o_unit_code,
  output logic                   o_nvm_wr,
  output logic [7:0]             o_nvm_wr_data,
  output logic                   o_test_start,
  output logic                   o_rewind_unload
);

  import panel_pkg::*;

  panel_state_t state_reg;
  logic [31:0]  timer_reg;
  logic [7:0]   unit_code_reg;
  logic [7:0]   proc_reg;
  logic [3:0]   pattern_reg;
  disp_t        entry_reg;
  logic [11:0]  fault_code_reg;
  logic         armed_reg;
  lamps_t       lamps_reg;
  disp_t        display_reg;
  logic         nvm_wr_reg;
  logic [7:0]   nvm_wr_data_reg;
  logic         test_start_reg;
  logic         rewind_reg;

  logic [KEY_COUNT-1:0] key_level;
  logic [KEY_COUNT-1:0] key_press;
  logic                 press_reset;
  logic                 press_select;
  logic                 press_advance;
  logic                 press_run;
  logic [9:0]           entry_value;
  logic                 step_end;
  logic                 lamp_end;

  // one edge detector per panel key
  assign key_level = i_keys;

  for (genvar k = 0; k < KEY_COUNT; k++) begin : g_key
    panel_key_edge #(
      .ACTIVE_LEVEL (1'b1)
    ) u_edge (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_level    (key_level[k]),
      .o_press    (key_press[k])
    );
  end

  assign press_reset   = key_press[KEY_RESET];
  assign press_select  = key_press[KEY_SELECT];
  assign press_advance = key_press[KEY_ADVANCE];
  assign press_run     = key_press[KEY_RUN];

  // entered three digits as a binary value
  assign entry_value = 10'(entry_reg.hundreds) * 10'd100
                     + 10'(entry_reg.tens) * 10'd10
                     + 10'(entry_reg.ones); // R10

  // timer end marks
  assign step_end = (timer_reg >= 32'(DIGIT_STEP_CYCLES - 1));
  assign lamp_end = (timer_reg >= 32'(LAMP_TEST_CYCLES - 1));

  // binary unit code to three BCD digits
  function automatic disp_t show_unit(input logic [7:0] v);
    logic [7:0] r;
    r = v % 8'd100;
    show_unit.blank_hi = 1'b0;
    show_unit.hundreds = 4'(v / 8'd100);
    show_unit.tens     = 4'(r / 8'd10);
    show_unit.ones     = 4'(r % 8'd10);
  endfunction

  // two-digit BCD value with the hundreds digit blanked
  function automatic disp_t show_two(input logic [7:0] v);
    show_two.blank_hi = 1'b1;
    show_two.hundreds = 4'h0;
    show_two.tens     = v[7:4];
    show_two.ones     = v[3:0];
  endfunction

  // two-digit BCD increment, wrapping back to the first procedure
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v == PROC_LAST) begin
      bcd_inc = PROC_FIRST;
    end else if (v[3:0] == DIGIT_LAST) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // main sequence and step timer
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state_reg <= ST_POWERON;
      timer_reg <= 32'h0000_0000;
    end else begin
      timer_reg <= timer_reg + 32'h0000_0001;
      case (state_reg)
        ST_POWERON: begin
          timer_reg <= 32'h0000_0000;
          if (!i_power_ok) begin
            state_reg <= ST_PWR_FAIL; // R2
          end else begin
            state_reg <= ST_LAMP_ON; // R1
          end
        end
        ST_PWR_FAIL: begin
          state_reg <= ST_PWR_FAIL; // R2
        end
        ST_LAMP_ON: begin
          if (lamp_end) begin
            state_reg <= ST_LAMP_OFF; // R1
            timer_reg <= 32'h0000_0000;
          end
        end
        ST_LAMP_OFF: begin
          if (lamp_end) begin
            state_reg <= ST_NORMAL; // R1
          end
        end
        ST_NORMAL: begin
          if (press_select && armed_reg) begin
            state_reg <= ST_DIAG_SEL; // R3
          end
        end
        ST_DIAG_SEL: begin
          if (press_reset) begin
            state_reg <= ST_NORMAL; // R8
          end else if (press_run && proc_reg == PROC_FIRST) begin
            state_reg <= ST_DISP_EX; // R4
            timer_reg <= 32'h0000_0000;
          end else if (press_run && proc_reg == PROC_UNIT) begin
            state_reg <= ST_ENTRY; // R14
          end
        end
        ST_DISP_EX: begin
          if (press_reset) begin
            state_reg <= ST_NORMAL; // R8
          end else if (step_end) begin
            timer_reg <= 32'h0000_0000;
            if (pattern_reg == PATTERN_LAST) begin
              state_reg <= ST_TAPE_TEST; // R4
            end
          end
        end
        ST_TAPE_TEST: begin
          if (press_reset) begin
            state_reg <= ST_NORMAL; // R8
          end else if (i_test_fault) begin
            state_reg <= ST_FAULT; // R7
          end else if (i_test_done) begin
            state_reg <= ST_TEST_DONE; // R6
          end
        end
        ST_FAULT: begin
          if (press_reset) begin
            state_reg <= ST_DIAG_SEL; // R9
          end
        end
        ST_ENTRY: begin
          if (press_reset) begin
            state_reg <= ST_NORMAL; // R8
          end else if (press_run && entry_value > UNIT_MAX) begin
            state_reg <= ST_FAULT; // R17
          end else if (press_run) begin
            state_reg <= ST_STORED; // R16
          end
        end
        ST_TEST_DONE, ST_STORED: begin
          if (press_reset) begin
            state_reg <= ST_NORMAL; // R8 R16
          end
        end
        default: begin
          state_reg <= ST_POWERON;
        end
      endcase
    end
  end

  // reset-then-select arming in normal operation
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      armed_reg <= 1'b0;
    end else if (state_reg != ST_NORMAL) begin
      armed_reg <= 1'b0;
    end else if (press_reset) begin
      armed_reg <= 1'b1; // R3
    end else if (press_advance || press_run) begin
      armed_reg <= 1'b0;
    end
  end

  // procedure number selection
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      proc_reg <= PROC_FIRST;
    end else if (state_reg == ST_NORMAL || state_reg == ST_FAULT) begin
      proc_reg <= PROC_FIRST; // R3 R9
    end else if (state_reg == ST_DIAG_SEL && press_advance) begin
      proc_reg <= bcd_inc(proc_reg); // R13
    end
  end

  // display exercise pattern digit
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      pattern_reg <= 4'h0;
    end else if (state_reg != ST_DISP_EX) begin
      pattern_reg <= 4'h0;
    end else if (step_end && pattern_reg != PATTERN_LAST) begin
      pattern_reg <= pattern_reg + 4'h1; // R4
    end
  end

  // unit code digit entry
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      entry_reg <= '0;
    end else if (state_reg != ST_ENTRY) begin
      entry_reg <= '0; // R14
    end else if (press_advance) begin
      if (entry_reg.ones == DIGIT_LAST) begin
        entry_reg.ones <= 4'h0;
      end else begin
        entry_reg.ones <= entry_reg.ones + 4'h1; // R15
      end
    end else if (press_select) begin
      entry_reg.hundreds <= entry_reg.tens; // R15
      entry_reg.tens     <= entry_reg.ones;
      entry_reg.ones     <= 4'h0;
    end
  end

  // stored unit code, loaded from the nonvolatile store after reset
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      unit_code_reg <= UNIT_RESET;
    end else if (state_reg == ST_POWERON) begin
      unit_code_reg <= i_nvm_code; // R11
    end else if (state_reg == ST_ENTRY && press_run && !press_reset
                 && entry_value <= UNIT_MAX) begin
      unit_code_reg <= entry_value[7:0]; // R16 R17
    end
  end

  // nonvolatile write strobe and data
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      nvm_wr_reg      <= 1'b0;
      nvm_wr_data_reg <= UNIT_RESET;
    end else begin
      nvm_wr_reg <= 1'b0;
      if (state_reg == ST_ENTRY && press_run && !press_reset
          && entry_value <= UNIT_MAX) begin
        nvm_wr_reg      <= 1'b1; // R11 R16
        nvm_wr_data_reg <= entry_value[7:0];
      end
    end
  end

  // latched fault code
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      fault_code_reg <= 12'h000;
    end else if (state_reg == ST_TAPE_TEST && i_test_fault && !press_reset) begin
      fault_code_reg <= i_test_fault_code; // R7
    end else if (state_reg == ST_ENTRY && press_run && !press_reset
                 && entry_value > UNIT_MAX) begin
      fault_code_reg <= RANGE_FAULT_CODE; // R17
    end
  end

  // test start and rewind-unload command pulses
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      test_start_reg <= 1'b0;
      rewind_reg     <= 1'b0;
    end else begin
      test_start_reg <= state_reg == ST_DISP_EX && !press_reset && step_end
                        && pattern_reg == PATTERN_LAST;
      rewind_reg     <= state_reg == ST_TAPE_TEST && !press_reset
                        && !i_test_fault && i_test_done; // R6
    end
  end

  // lamps per state
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      lamps_reg <= '0;
    end else begin
      lamps_reg <= '0;
      case (state_reg)
        ST_POWERON: begin
          lamps_reg <= '0;
        end
        ST_PWR_FAIL: begin
          lamps_reg.power_fail_lamp <= 1'b1; // R2
          lamps_reg.fault_lamp      <= 1'b1;
        end
        ST_LAMP_ON: begin
          lamps_reg <= '1; // R1
        end
        ST_LAMP_OFF: begin
          lamps_reg <= '0; // R1
        end
        ST_NORMAL: begin
          lamps_reg.power_good_lamp    <= 1'b1; // R1
          lamps_reg.write_protect_lamp <= 1'b1;
          lamps_reg.online_lamp        <= i_status.online;
          lamps_reg.tape_start_lamp    <= i_status.at_tape_start;
          lamps_reg.high_density_lamp  <= i_status.high_density;
        end
        ST_DISP_EX: begin
          lamps_reg                 <= '1; // R4 R5
          lamps_reg.power_fail_lamp <= 1'b0;
          lamps_reg.tape_start_lamp <= 1'b0;
          lamps_reg.fault_lamp      <= 1'b0;
        end
        ST_FAULT, ST_TEST_DONE: begin
          lamps_reg.power_good_lamp    <= 1'b1;
          lamps_reg.write_protect_lamp <= 1'b1;
          lamps_reg.diag_mode_lamp     <= 1'b1;
          lamps_reg.fault_lamp         <= 1'b1; // R6 R7
        end
        default: begin
          lamps_reg.power_good_lamp    <= 1'b1;
          lamps_reg.write_protect_lamp <= 1'b1;
          lamps_reg.diag_mode_lamp     <= 1'b1; // R3
        end
      endcase
    end
  end

  // display contents per state
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      display_reg <= '0;
    end else begin
      case (state_reg)
        ST_PWR_FAIL: begin
          display_reg <= {1'b0, POWER_FAULT_CODE}; // R2
        end
        ST_LAMP_ON: begin
          display_reg <= {1'b0, 12'h888};
        end
        ST_DIAG_SEL, ST_TAPE_TEST: begin
          display_reg <= show_two(proc_reg); // R3 R12 R13
        end
        ST_DISP_EX: begin
          display_reg <= {1'b0, pattern_reg, pattern_reg, pattern_reg}; // R4
        end
        ST_FAULT: begin
          display_reg <= {1'b0, fault_code_reg}; // R7 R17
        end
        ST_TEST_DONE, ST_STORED: begin
          display_reg <= show_two(DONE_CODE); // R6 R16
        end
        ST_ENTRY: begin
          display_reg <= entry_reg; // R14 R15
        end
        default: begin
          display_reg <= show_unit(unit_code_reg); // R12
        end
      endcase
    end
  end

  // outputs from flip-flops
  assign o_lamps         = lamps_reg;
  assign o_display       = display_reg;
  assign o_unit_code     = unit_code_reg;
  assign o_nvm_wr        = nvm_wr_reg;
  assign o_nvm_wr_data   = nvm_wr_data_reg;
  assign o_test_start    = test_start_reg;
  assign o_rewind_unload = rewind_reg;

endmodule

`default_nettype wire

// ---- hw/panel_key_edge.sv ----
// key press detector: one-cycle pulse on the active edge of a panel key
`timescale 1ns/100ps
`default_nettype none

module panel_key_edge #(
  parameter bit ACTIVE_LEVEL = 1'b1
) (
  input  wire logic i_core_clk,
  input  wire logic i_nrst,
  input  wire logic i_level,
  output logic      o_press
);

  logic prev_reg;
  logic active;

  // level normalised to active high
  assign active = (i_level == ACTIVE_LEVEL);

  // previous sample, set to pressed after reset so a held key gives no press
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= active;
    end
  end

  // pulse only on the newly pressed cycle
  assign o_press = active & ~prev_reg;

endmodule

`default_nettype wire

// ---- shared/panel_pkg.sv ----
// package: constants and types for the front-panel diagnostic and unit code controller
package panel_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int LAMP_TEST_MS  = 500;
  localparam int LAMP_TEST_CYC = LAMP_TEST_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int DIGIT_STEP_MS  = 250;
  localparam int DIGIT_STEP_CYC = DIGIT_STEP_MS * 1_000_000 / CLK_PERIOD_NS;

  // procedure numbers and display codes (two-digit BCD)
  localparam logic [7:0] PROC_FIRST  = 8'h01;
  localparam logic [7:0] PROC_UNIT   = 8'h04;
  localparam logic [7:0] PROC_LAST   = 8'h99;
  localparam logic [7:0] DONE_CODE   = 8'h00;

  // unit code limits and reset value
  localparam logic [9:0] UNIT_MAX    = 10'h0FF;
  localparam logic [7:0] UNIT_RESET  = 8'h00;

  // display exercise last pattern digit and last decimal digit
  localparam logic [3:0] PATTERN_LAST = 4'h9;
  localparam logic [3:0] DIGIT_LAST   = 4'h9;

  // fault codes shown by the block itself (three-digit BCD)
  localparam logic [11:0] RANGE_FAULT_CODE = 12'h030;
  localparam logic [11:0] POWER_FAULT_CODE = 12'h031;

  // key bit positions in the key vector
  localparam int KEY_RESET   = 3;
  localparam int KEY_SELECT  = 2;
  localparam int KEY_ADVANCE = 1;
  localparam int KEY_RUN     = 0;
  localparam int KEY_COUNT   = 4;

  typedef enum logic [3:0] {
    ST_POWERON,
    ST_PWR_FAIL,
    ST_LAMP_ON,
    ST_LAMP_OFF,
    ST_NORMAL,
    ST_DIAG_SEL,
    ST_DISP_EX,
    ST_TAPE_TEST,
    ST_TEST_DONE,
    ST_FAULT,
    ST_ENTRY,
    ST_STORED
  } panel_state_t;

  typedef struct packed {
    logic power_good_lamp;
    logic power_fail_lamp;
    logic write_protect_lamp;
    logic online_lamp;
    logic tape_start_lamp;
    logic high_density_lamp;
    logic diag_mode_lamp;
    logic fault_lamp;
  } lamps_t;

  typedef struct packed {
    logic       blank_hi;
    logic [3:0] hundreds;
    logic [3:0] tens;
    logic [3:0] ones;
  } disp_t;

  typedef struct packed {
    logic online;
    logic at_tape_start;
    logic high_density;
  } status_t;

  typedef struct packed {
    logic reset_key;
    logic select_key;
    logic advance_key;
    logic run_key;
  } keys_t;

endpackage

// ---- verif/panel_ctrl_sva.sv ----
// checker: port behaviour of the panel controller
`timescale 1ns/100ps
`default_nettype none
module panel_ctrl_sva
  import panel_pkg::*;
#(
  parameter int LAMP_TEST_CYCLES  = 8,
  parameter int DIGIT_STEP_CYCLES = 4
) (
  input wire logic              i_core_clk,
  input wire logic              i_nrst,
  input wire logic              i_test_fault,
  input wire logic [11:0]       i_test_fault_code,
  input wire panel_pkg::lamps_t o_lamps,
  input wire panel_pkg::disp_t  o_display,
  input wire logic [7:0]        o_unit_code,
  input wire logic              o_nvm_wr,
  input wire logic [7:0]        o_nvm_wr_data,
  input wire logic              o_test_start,
  input wire logic              o_rewind_unload
);
  logic ex;
  logic tape_reg;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // display exercise is the only state with diag and online lamps lit, fault dark
  assign ex = o_lamps.diag_mode_lamp && o_lamps.online_lamp && !o_lamps.fault_lamp;
  // tape phase: from the start pulse until the diag lamp drops or the fault lamp lights
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst || o_lamps.fault_lamp || !o_lamps.diag_mode_lamp) begin
      tape_reg <= 1'b0;
    end else if (o_test_start) begin
      tape_reg <= 1'b1;
    end
  end
  // end states of a test
  sequence s_done_shown;
    o_lamps.fault_lamp && o_lamps.diag_mode_lamp && o_display == 13'h1000;
  endsequence
  sequence s_fault_shown;
    o_lamps.fault_lamp && o_display == {1'b0, i_test_fault_code};
  endsequence
  a_fail_lamps: assert property (o_lamps.power_fail_lamp && !o_lamps.power_good_lamp |-> o_lamps.fault_lamp)
    else $error("power fail lamps wrong");
  a_exercise_lamps: assert property (ex |-> (o_lamps & 8'hED) == 8'hA4)
    else $error("exercise lamps wrong");
  a_exercise_digits: assert property (ex |-> !o_display.blank_hi && o_display.hundreds == o_display.tens)
    else $error("exercise digits differ");
  a_pattern_step: assert property (ex && $past(ex) && $changed(o_display) |-> o_display.ones == $past(o_display.ones) + 4'h1)
    else $error("exercise pattern skipped");
  a_pattern_span: assert property (o_test_start |-> $past(o_display) == 13'h0999)
    else $error("exercise ended early");
  a_store_echo: assert property (o_nvm_wr |-> o_nvm_wr_data == o_unit_code ##1 o_display == 13'h1000)
    else $error("store write wrong");
  a_code_stored: assert property ($changed(o_unit_code) && o_lamps.power_good_lamp |-> o_nvm_wr)
    else $error("unit code changed without store");
  a_diag_entry: assert property ($rose(o_lamps.diag_mode_lamp) && !o_lamps.online_lamp && !o_lamps.fault_lamp |-> o_display == 13'h1001)
    else $error("diag entry display wrong");
  a_fault_code: assert property (tape_reg && i_test_fault |-> ##[1:2] s_fault_shown)
    else $error("test fault not shown");
  a_done_shown: assert property (o_rewind_unload |-> ##[0:1] s_done_shown)
    else $error("test done not shown");
endmodule
bind panel_ctrl panel_ctrl_sva #(
  .LAMP_TEST_CYCLES (LAMP_TEST_CYCLES),
  .DIGIT_STEP_CYCLES(DIGIT_STEP_CYCLES)
) panel_ctrl_sva_i (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_test_fault(i_test_fault),
  .i_test_fault_code(i_test_fault_code), .o_lamps(o_lamps), .o_display(o_display),
  .o_unit_code(o_unit_code), .o_nvm_wr(o_nvm_wr), .o_nvm_wr_data(o_nvm_wr_data),
  .o_test_start(o_test_start), .o_rewind_unload(o_rewind_unload)
);
`default_nettype wire

// ---- verif/panel_operator.sv ----
// operator model: presses panel keys on request, held for a chosen span
`timescale 1ns/100ps
`default_nettype none
module panel_operator
  import panel_pkg::*;
(
  input  wire logic             i_core_clk,
  input  wire logic             i_nrst,
  input  wire panel_pkg::keys_t i_req,
  input  wire logic [3:0]       i_hold,
  output panel_pkg::keys_t      o_keys,
  output logic                  o_idle
);
  logic [3:0] cnt_reg;
  // hold the key, release it, keep two released cycles before the next press
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_keys  <= '0;
      cnt_reg <= 4'h0;
      o_idle  <= 1'b1;
    end else if (o_idle && (|i_req)) begin
      o_keys  <= i_req;
      cnt_reg <= i_hold;
      o_idle  <= 1'b0;
    end else if (!o_idle) begin
      if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end else if (|o_keys) begin
        o_keys <= '0;
      end else begin
        o_idle <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb_panel_ctrl.sv ----
// testbench: panel controller driven through the operator model
`timescale 1ns/100ps
`default_nettype none
module tb_panel_ctrl;
  import panel_pkg::*;
  localparam int LT = 8;
  localparam int DS = 4;
  logic        i_core_clk;
  logic        i_nrst;
  keys_t       i_keys;
  keys_t       req;
  logic [3:0]  hold;
  logic        idle;
  logic        i_power_ok;
  status_t     i_status;
  logic        i_test_done;
  logic        i_test_fault;
  logic [11:0] i_test_fault_code;
  logic [7:0]  i_nvm_code;
  lamps_t      o_lamps;
  disp_t       o_display;
  logic [7:0]  o_unit_code;
  logic        o_nvm_wr;
  logic [7:0]  o_nvm_wr_data;
  logic        o_test_start;
  logic        o_rewind_unload;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          n_wr = 0;
  int          n_rw = 0;
  int          n_start = 0;
  int          code;
  int          vals[5];

  panel_ctrl #(.LAMP_TEST_CYCLES(LT), .DIGIT_STEP_CYCLES(DS)) panel_ctrl_i (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_keys(i_keys), .i_power_ok(i_power_ok),
    .i_status(i_status), .i_test_done(i_test_done), .i_test_fault(i_test_fault),
    .i_test_fault_code(i_test_fault_code), .i_nvm_code(i_nvm_code), .o_lamps(o_lamps),
    .o_display(o_display), .o_unit_code(o_unit_code), .o_nvm_wr(o_nvm_wr),
    .o_nvm_wr_data(o_nvm_wr_data), .o_test_start(o_test_start), .o_rewind_unload(o_rewind_unload)
  );
  panel_operator panel_operator_i (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_req(req), .i_hold(hold), .o_keys(i_keys), .o_idle(idle)
  );

  // clock
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  // nonvolatile store model and pulse counters
  always @(posedge i_core_clk) begin
    if (o_nvm_wr) begin
      i_nvm_code <= o_nvm_wr_data;
      n_wr <= n_wr + 1;
    end
    if (o_rewind_unload) begin
      n_rw <= n_rw + 1;
    end
    if (o_test_start) begin
      n_start <= n_start + 1;
    end
  end

  function automatic disp_t bcd(input int v);
    return {1'b0, 4'(v / 100), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction

  function automatic logic [7:0] normal_lamps(input status_t s);
    return {3'h5, s, 2'h0};
  endfunction

  task automatic chk_disp(input disp_t got, input disp_t exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one key press with a random hold, returns once settled
  task automatic press(input int k);
    @(posedge i_core_clk);
    req  <= keys_t'(4'(1 << k));
    hold <= 4'($urandom_range(0, 3));
    @(posedge i_core_clk);
    req <= '0;
    repeat (60) begin
      @(negedge i_core_clk);
      if (idle) break;
    end
    repeat (2) @(negedge i_core_clk);
  endtask

  task automatic wait_lamps(input logic [7:0] m, input logic [7:0] v);
    repeat (400) begin
      @(negedge i_core_clk);
      if ((o_lamps & m) === v) break;
    end
  endtask

  task automatic do_reset();
    @(posedge i_core_clk);
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    i_nrst <= 1'b1;
  endtask

  task automatic power_up();
    do_reset();
    wait_lamps(8'hFF, 8'hFF);
    chk8(o_lamps, 8'hFF);
    wait_lamps(8'hFF, 8'h00);
    chk8(o_lamps, 8'h00);
    wait_lamps(8'h80, 8'h80);
    repeat (2) @(negedge i_core_clk);
    chk8(o_lamps, normal_lamps(i_status));
    chk_disp(o_display, bcd(code));
  endtask

  // procedure 04: enter v digit by digit, then store
  task automatic enter_code(input int v);
    int d[3];
    int wr0;
    d = '{v / 100, v / 10 % 10, v % 10};
    wr0 = n_wr;
    press(KEY_RESET);
    press(KEY_SELECT);
    chk_disp(o_display, 13'h1001);
    chk8(o_lamps, 8'hA2);
    repeat (3) press(KEY_ADVANCE);
    chk_disp(o_display, 13'h1004);
    press(KEY_RUN);
    chk_disp(o_display, 13'h0000);
    for (int i = 0; i < 3; i++) begin
      if (i > 0) begin
        press(KEY_SELECT);
      end
      repeat (d[i]) press(KEY_ADVANCE);
      chk_disp(o_display, bcd(v / (10 ** (2 - i))));
    end
    press(KEY_RUN);
    if (v <= 255) begin
      chk_disp(o_display, 13'h1000);
      chk8(o_unit_code, 8'(v));
      chk8(8'(n_wr - wr0), 8'h01);
      code = v;
      press(KEY_RESET);
    end else begin
      chk_disp(o_display, {1'b0, RANGE_FAULT_CODE});
      chk8(o_unit_code, 8'(code));
      chk8(8'(n_wr - wr0), 8'h00);
      press(KEY_RESET);
      chk_disp(o_display, 13'h1001);
      press(KEY_RESET);
    end
    chk_disp(o_display, bcd(code));
    chk8(o_lamps, normal_lamps(i_status));
  endtask

  // test 01 from the selected state, ending in a fault or a clean finish
  task automatic run_test(input logic fail);
    int st0;
    int rw0;
    st0 = n_start;
    rw0 = n_rw;
    @(posedge i_core_clk);
    i_test_fault_code <= {4'($urandom_range(0, 9)), 4'($urandom_range(0, 9)), 4'($urandom_range(0, 9))};
    press(KEY_RUN);
    chk8(o_lamps, 8'hB6);
    repeat (200) begin
      @(negedge i_core_clk);
      if (n_start != st0) break;
    end
    chk8(8'(n_start - st0), 8'h01);
    @(posedge i_core_clk);
    i_test_fault <= fail;
    i_test_done  <= ~fail;
    @(posedge i_core_clk);
    i_test_fault <= 1'b0;
    i_test_done  <= 1'b0;
    repeat (3) @(negedge i_core_clk);
    chk_disp(o_display, fail ? disp_t'({1'b0, i_test_fault_code}) : disp_t'(13'h1000));
    chk8({6'h00, o_lamps.diag_mode_lamp | fail, o_lamps.fault_lamp}, 8'h03);
    chk8(8'(n_rw - rw0), {7'h00, ~fail});
  endtask

  task automatic complete_run();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (30000) @(posedge i_core_clk);
    n_fail++;
    complete_run();
  end

  // main sequence
  initial begin
    void'($urandom(38170));
    i_nrst = 1'b0;
    req = '0;
    hold = 4'h0;
    i_power_ok = 1'b1;
    i_status = status_t'(3'($urandom_range(0, 7)));
    i_test_done = 1'b0;
    i_test_fault = 1'b0;
    i_test_fault_code = 12'h000;
    i_nvm_code = 8'($urandom_range(0, 255));
    code = int'(i_nvm_code);
    vals = '{201, 0, 255, 256, 0};
    vals[1] = $urandom_range(0, 254);
    vals[4] = $urandom_range(257, 999);
    power_up();
    foreach (vals[i]) begin
      @(posedge i_core_clk);
      i_status <= status_t'(3'($urandom_range(0, 7)));
      enter_code(vals[i]);
    end
    power_up();
    press(KEY_RESET);
    press(KEY_SELECT);
    run_test(1'b1);
    press(KEY_RESET);
    chk_disp(o_display, 13'h1001);
    run_test(1'b0);
    press(KEY_RESET);
    chk_disp(o_display, bcd(code));
    @(posedge i_core_clk);
    i_power_ok <= 1'b0;
    do_reset();
    repeat (LT * 3) @(negedge i_core_clk);
    press(KEY_RUN);
    chk8({5'h00, o_lamps.power_good_lamp, o_lamps.power_fail_lamp, o_lamps.fault_lamp}, 8'h03);
    chk_disp(o_display, {1'b0, POWER_FAULT_CODE});
    complete_run();
  end
endmodule
`default_nettype wire
